// ==== common/bridge_fault_consts.vh ====
// Constants for the bridge fault supervisor
`ifndef BRIDGE_FAULT_CONSTS_VH
`define BRIDGE_FAULT_CONSTS_VH

`define CLK_PERIOD_NS 10
`define SUPPLY_LOW_FILTER_NS 1000
`define SUPPLY_LOW_FILTER_CYC ((`SUPPLY_LOW_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOGIC_LOW_FILTER_NS 1000
`define LOGIC_LOW_FILTER_CYC ((`LOGIC_LOW_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOGIC_HIGH_FILTER_NS 100000
`define LOGIC_HIGH_FILTER_CYC ((`LOGIC_HIGH_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_SETTLE_NS 10000
`define IDLE_SETTLE_CYC ((`IDLE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_DIAG 4'h0
`define REG_CTRL 4'h4
`define REG_IRQ_STATUS 4'h8
`define REG_IRQ_MASK 4'hC

`define DIAG_SUPPLY_LOW 0
`define DIAG_OPEN_LOAD 1
`define DIAG_SHORT_GND 2
`define DIAG_LOGIC_HIGH 3
`define DIAG_CUR_REG 4
`define DIAG_THERM_WARN 5
`define DIAG_THERM_SD 6
`define DIAG_BRIDGE_ON 7
`define DIAG_OVERCUR_LSB 8
`define DIAG_SHORT_BAT 12

`define CTRL_CLEAR_POLICY 0
`define CTRL_RESET 1'h0

`define EV_SUPPLY_LOW 0
`define EV_LOGIC_HIGH 1
`define EV_OFF_DIAG 2
`define EV_OVERCUR 3
`define EV_THERM_SD 4
`define EV_WIDTH 5

`define MEAS_SHORT_GND_MIN 8'hC0
`define MEAS_SHORT_BAT_MAX 8'h40
`define MEAS_OPEN_MIN 8'h78
`define MEAS_OPEN_MAX 8'h88

`endif

// ==== dv/bridge_fault_supervisor_sva.sv ====
// Port assertions for the bridge fault supervisor
module supervisor_sva #(
    parameter LOGIC_HIGH_FILTER_CYC = 20
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire avs_waitrequest_out,
    input wire supply_below_trip_in,
    input wire logic_above_trip_in,
    input wire logic_below_trip_in,
    input wire polarity_select_in,
    input wire switching_pulse_in,
    input wire bridge_terminal_a_out,
    input wire bridge_terminal_a_oe_n_out,
    input wire bridge_terminal_b_oe_n_out,
    input wire meas_source_en_out,
    input wire sleep_out
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [16:0] sup_cnt_ff;
    reg [16:0] hi_cnt_ff;
    reg [16:0] lo_cnt_ff;
    wire hiz = bridge_terminal_a_oe_n_out && bridge_terminal_b_oe_n_out;
    // Run lengths of each raw condition; margin of a few edges for the registered outputs
    always @(posedge ref_clk_in) begin
        sup_cnt_ff <= (reset_in || !supply_below_trip_in) ? 17'h0 : sup_cnt_ff + 17'h1;
        hi_cnt_ff <= (reset_in || !logic_above_trip_in) ? 17'h0 : hi_cnt_ff + 17'h1;
        lo_cnt_ff <= (reset_in || !logic_below_trip_in) ? 17'h0 : lo_cnt_ff + 17'h1;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_slept;
        sleep_out [*2];
    endsequence
    property p_wait_ans;
        s_req |=> !avs_waitrequest_out;
    endproperty
    property p_wait_one;
        $fell(avs_waitrequest_out) |=> avs_waitrequest_out;
    endproperty
    property p_wait_idle;
        !(avs_read_in || avs_write_in) |=> avs_waitrequest_out;
    endproperty
    property p_sup_off;
        sup_cnt_ff >= 17'd103 |-> hiz;
    endproperty
    property p_src_off;
        sup_cnt_ff >= 17'd103 |-> !meas_source_en_out;
    endproperty
    property p_hi_off;
        hi_cnt_ff >= LOGIC_HIGH_FILTER_CYC + 3 |-> hiz;
    endproperty
    property p_sleep;
        lo_cnt_ff >= 17'd103 |-> sleep_out;
    endproperty
    property p_sleep_hiz;
        s_slept |-> hiz;
    endproperty
    property p_drive;
        !bridge_terminal_a_oe_n_out |->
            bridge_terminal_a_out == $past(switching_pulse_in && polarity_select_in);
    endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no answer after request");
    a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
    a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
    a_sup_off: assert property (p_sup_off) else $error("bridge driven in supply low");
    a_src_off: assert property (p_src_off) else $error("source on in supply low");
    a_hi_off: assert property (p_hi_off) else $error("bridge driven in logic high");
    a_sleep: assert property (p_sleep) else $error("no sleep in logic low");
    a_sleep_hiz: assert property (p_sleep_hiz) else $error("bridge driven in sleep");
    a_drive: assert property (p_drive) else $error("terminal a drive wrong");
endmodule

bind bridge_fault_supervisor supervisor_sva #(.LOGIC_HIGH_FILTER_CYC(LOGIC_HIGH_FILTER_CYC)) u_sva (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
    .supply_below_trip_in(supply_below_trip_in), .logic_above_trip_in(logic_above_trip_in),
    .logic_below_trip_in(logic_below_trip_in), .polarity_select_in(polarity_select_in),
    .switching_pulse_in(switching_pulse_in), .bridge_terminal_a_out(bridge_terminal_a_out),
    .bridge_terminal_a_oe_n_out(bridge_terminal_a_oe_n_out),
    .bridge_terminal_b_oe_n_out(bridge_terminal_b_oe_n_out),
    .meas_source_en_out(meas_source_en_out), .sleep_out(sleep_out));

// ==== dv/bridge_fault_supervisor_test.sv ====
// Directed testbench for the bridge fault supervisor
`include "bridge_fault_consts.vh"
module bridge_fault_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, sup_lo, sup_rec, lg_hi, lg_lo, lg_rec, cur_reg, t_warn, shut;
    logic [7:0] meas;
    wire [3:0] addr;
    wire rd, wr, wait_n, irq, en, pol, pul, term_a, oe_a, oe_b, src, slp, failure_summary_indicator;
    wire [31:0] wdata, rdata;
    int n_fail = 0;
    int cmp_count = 0;
    logic [7:0] codes [3] = '{8'hC0, 8'h40, 8'h80};
    logic [31:0] bits [3] = '{32'h4, 32'h1000, 32'h2};
    mcu_model u_mcu (.ref_clk_in(clk), .avs_readdata_in(rdata), .avs_waitrequest_in(wait_n),
        .avs_address_out(addr), .avs_read_out(rd), .avs_write_out(wr),
        .avs_writedata_out(wdata), .enable_out(en), .polarity_select_out(pol),
        .switching_pulse_out(pul));
    // Short filter and settle counts keep the run brief
    bridge_fault_supervisor #(.LOGIC_HIGH_FILTER_CYC(20), .IDLE_SETTLE_CYC(5)) uut (
        .ref_clk_in(clk), .reset_in(rst), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_n), .irq_out(irq),
        .supply_below_trip_in(sup_lo), .supply_above_recover_in(sup_rec),
        .logic_above_trip_in(lg_hi), .logic_below_trip_in(lg_lo),
        .logic_above_recover_in(lg_rec), .enable_in(en), .shutoff_input_in(shut),
        .polarity_select_in(pol), .switching_pulse_in(pul), .current_regulating_in(cur_reg),
        .thermal_warning_in(t_warn), .thermal_shutdown_in(1'b0), .overcurrent_in(4'h0),
        .meas_current_in(meas), .bridge_terminal_a_out(term_a),
        .bridge_terminal_a_oe_n_out(oe_a), .bridge_terminal_b_out(),
        .bridge_terminal_b_oe_n_out(oe_b), .meas_source_en_out(src), .sleep_out(slp),
        .failure_summary_indicator_out(failure_summary_indicator));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic eq(input [31:0] g, input [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic eqb(input g, input e);
        eq({31'h0, g}, {31'h0, e});
    endtask
    task automatic chk(input [3:0] a, input [31:0] e);
        logic [31:0] d;
        u_mcu.rd(a, d);
        eq(d, e);
    endtask
    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        cyc(20000);
        n_fail++;
        final_report();
    end
    initial begin
        {rst, sup_rec, lg_rec} = 3'h7;
        {sup_lo, lg_hi, lg_lo, cur_reg, t_warn, shut} = 6'h0;
        meas = 8'h60;
        cyc(12);
        rst <= 1'b0;
        chk(`REG_CTRL, 32'h0);
        chk(`REG_IRQ_MASK, 32'h0);
        chk(4'h2, 32'h0);
        chk(`REG_DIAG, 32'h0);
        u_mcu.drive(1'b1, 1'b1, 1'b1);
        cur_reg <= 1'b1;
        t_warn <= 1'b1;
        cyc(10);
        eqb(oe_a, 1'b0);
        eqb(term_a, 1'b1);
        chk(`REG_DIAG, 32'hB0);
        {cur_reg, t_warn} <= 2'h0;
        cyc(2);
        chk(`REG_DIAG, 32'hB0);
        chk(`REG_DIAG, 32'h80);
        u_mcu.wr(`REG_CTRL, 32'h1);
        u_mcu.wr(`REG_IRQ_MASK, 32'h1);
        repeat (2) begin
            sup_lo <= 1'b1;
            cyc(60);
            sup_lo <= 1'b0;
            cyc(1);
        end
        eqb(oe_a, 1'b0);
        {sup_lo, sup_rec} <= 2'h2;
        cyc(110);
        eqb(oe_a, 1'b1);
        eqb(failure_summary_indicator, 1'b1);
        eqb(irq, 1'b1);
        chk(`REG_DIAG, 32'h1);
        chk(`REG_IRQ_STATUS, 32'h1);
        eqb(irq, 1'b0);
        sup_lo <= 1'b0;
        cyc(20);
        chk(`REG_DIAG, 32'h1);
        sup_rec <= 1'b1;
        cyc(5);
        chk(`REG_DIAG, 32'h80);
        eqb(oe_a, 1'b0);
        chk(`REG_CTRL, 32'h1);
        lg_hi <= 1'b1;
        cyc(25);
        lg_hi <= 1'b0;
        cyc(10);
        eqb(oe_a, 1'b1);
        chk(`REG_DIAG, 32'h8);
        chk(`REG_DIAG, 32'h8);
        u_mcu.drive(1'b0, 1'b1, 1'b1);
        cyc(3);
        u_mcu.drive(1'b1, 1'b1, 1'b1);
        cyc(5);
        chk(`REG_DIAG, 32'h80);
        shut <= 1'b1;
        cyc(3);
        eqb(oe_a, 1'b1);
        shut <= 1'b0;
        cyc(3);
        eqb(oe_a, 1'b0);
        u_mcu.wr(`REG_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            meas <= codes[i];
            u_mcu.drive(1'b0, 1'b1, 1'b1);
            cyc(3);
            chk(`REG_DIAG, 32'h0);
            eqb(src, 1'b1);
            cyc(15);
            chk(`REG_DIAG, bits[i]);
            u_mcu.drive(1'b1, 1'b1, 1'b1);
            cyc(5);
        end
        u_mcu.wr(`REG_CTRL, 32'h1);
        {lg_lo, lg_rec} <= 2'h2;
        cyc(110);
        eqb(slp, 1'b1);
        eqb(oe_a, 1'b1);
        {lg_lo, lg_rec} <= 2'h1;
        cyc(5);
        eqb(slp, 1'b0);
        chk(`REG_CTRL, 32'h0);
        chk(`REG_IRQ_MASK, 32'h0);
        final_report();
    end
endmodule

// ==== dv/mcu_model.sv ====
// Microcontroller model: register bus master and bridge drive inputs
module mcu_model (
    input wire ref_clk_in,
    input wire [31:0] avs_readdata_in,
    input wire avs_waitrequest_in,
    output logic [3:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [31:0] avs_writedata_out,
    output logic enable_out,
    output logic polarity_select_out,
    output logic switching_pulse_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {avs_address_out, avs_read_out, avs_write_out, avs_writedata_out} = 38'h0;
        {enable_out, polarity_select_out, switching_pulse_out} = 3'h0;
    end
    // Entered just after a rising edge; held until waitrequest is sampled low or 1000 edges pass
    task automatic xfer(input rw, input [3:0] a, input [31:0] wd, output [31:0] d);
        int n;
        begin
            avs_address_out <= a;
            avs_writedata_out <= wd;
            avs_read_out <= !rw;
            avs_write_out <= rw;
            n = 0;
            do begin
                @(posedge ref_clk_in);
                n++;
            end while (avs_waitrequest_in !== 1'b0 && n < 1000);
            d = avs_readdata_in;
            avs_read_out <= 1'b0;
            avs_write_out <= 1'b0;
            // Released bus shows inverted values, never the stale ones
            avs_address_out <= ~a;
            avs_writedata_out <= ~wd;
            @(posedge ref_clk_in);
        end
    endtask
    task automatic rd(input [3:0] a, output [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic wr(input [3:0] a, input [31:0] wd);
        logic [31:0] x;
        xfer(1'b1, a, wd, x);
    endtask
    task automatic drive(input en, input pol, input pul);
        enable_out <= en;
        polarity_select_out <= pol;
        switching_pulse_out <= pul;
    endtask
endmodule

// ==== rtl/bridge_fault_supervisor.v ====
// Fault supervision, off-state diagnosis and register slave for a motor bridge
`include "bridge_fault_consts.vh"
module bridge_fault_supervisor #(
    parameter LOGIC_HIGH_FILTER_CYC = `LOGIC_HIGH_FILTER_CYC,
    parameter IDLE_SETTLE_CYC = `IDLE_SETTLE_CYC
) (
    input wire ref_clk_in,
    input wire reset_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    output wire irq_out,
    input wire supply_below_trip_in,
    input wire supply_above_recover_in,
    input wire logic_above_trip_in,
    input wire logic_below_trip_in,
    input wire logic_above_recover_in,
    input wire enable_in,
    input wire shutoff_input_in,
    input wire polarity_select_in,
    input wire switching_pulse_in,
    input wire current_regulating_in,
    input wire thermal_warning_in,
    input wire thermal_shutdown_in,
    input wire [3:0] overcurrent_in,
    input wire [7:0] meas_current_in,
    output wire bridge_terminal_a_out,
    output wire bridge_terminal_a_oe_n_out,
    output wire bridge_terminal_b_out,
    output wire bridge_terminal_b_oe_n_out,
    output wire meas_source_en_out,
    output wire sleep_out,
    output wire failure_summary_indicator_out
);

    localparam ST_ON = 2'h0;
    localparam ST_SETTLE = 2'h1;
    localparam ST_MEASURE = 2'h2;
    localparam ST_DONE = 2'h3;

    // Saturating filter counter, restarts when the condition drops
    function [16:0] filt_next;
        input [16:0] cnt;
        input cond;
        input [16:0] limit;
        begin
            if (!cond) begin
                filt_next = 17'h0;
            end else if (cnt < limit) begin
                filt_next = cnt + 17'h1;
            end else begin
                filt_next = cnt;
            end
        end
    endfunction

    reg [16:0] sl_cnt_ff;
    reg [16:0] lh_cnt_ff;
    reg [16:0] ll_cnt_ff;
    reg [16:0] settle_cnt_ff;
    reg supply_low_ff;
    reg sleep_ff;
    reg restart_ff;
    reg logic_high_ff;
    reg open_load_ff;
    reg short_gnd_ff;
    reg short_bat_ff;
    reg cur_reg_ff;
    reg therm_warn_ff;
    reg therm_sd_ff;
    reg [3:0] overcur_ff;
    reg bridge_on_ff;
    reg active_prev_ff;
    reg first_diag_ff;
    reg [1:0] diag_state_ff;
    reg clear_policy_ff;
    reg [`EV_WIDTH-1:0] irq_stat_ff;
    reg [`EV_WIDTH-1:0] irq_mask_ff;
    reg irq_ff;
    reg [31:0] rdata_ff;
    reg wait_ff;
    reg term_a_ff;
    reg term_b_ff;
    reg oe_n_ff;
    reg source_en_ff;
    reg fsi_ff;

    reg [1:0] nxt_diag_state;
    reg [16:0] nxt_settle_cnt;
    reg nxt_open;
    reg nxt_sgnd;
    reg nxt_sbat;
    reg [31:0] nxt_rdata;

    // Logic supply recovery acts as a power-on reset for everything but the monitors and the bus answer
    wire soft_rst = reset_in | restart_ff;
    wire req = avs_read_in | avs_write_in;
    wire accept = req & ~wait_ff;
    wire rd_diag = accept & avs_read_in & (avs_address_in == `REG_DIAG);
    wire wr_ctrl = accept & avs_write_in & (avs_address_in == `REG_CTRL) & avs_byteenable_in[0];
    wire wr_mask = accept & avs_write_in & (avs_address_in == `REG_IRQ_MASK)
        & avs_byteenable_in[0];
    wire rd_stat = accept & avs_read_in & (avs_address_in == `REG_IRQ_STATUS);

    wire active = enable_in & ~shutoff_input_in;
    wire enable_edge = active & ~active_prev_ff;
    wire clr_any = enable_edge | rd_diag;
    wire clr_kept = enable_edge | (rd_diag & ~clear_policy_ff);

    wire [16:0] sl_nxt = filt_next(sl_cnt_ff, supply_below_trip_in,
        `SUPPLY_LOW_FILTER_CYC);
    wire [16:0] lh_nxt = filt_next(lh_cnt_ff, logic_above_trip_in,
        LOGIC_HIGH_FILTER_CYC[16:0]);
    wire [16:0] ll_nxt = filt_next(ll_cnt_ff, logic_below_trip_in & ~sleep_ff,
        `LOGIC_LOW_FILTER_CYC);
    wire sl_hit = (sl_nxt == `SUPPLY_LOW_FILTER_CYC);
    wire lh_hit = (lh_nxt == LOGIC_HIGH_FILTER_CYC[16:0]);
    wire ll_hit = (ll_nxt == `LOGIC_LOW_FILTER_CYC);

    wire nxt_supply_low = sl_hit | (supply_low_ff & ~supply_above_recover_in);
    wire nxt_logic_high = lh_hit | (logic_high_ff & ~clr_kept);
    wire nxt_therm_sd = thermal_shutdown_in | (therm_sd_ff & ~clr_kept);
    wire [3:0] nxt_overcur = overcurrent_in | (overcur_ff & ~{4{clr_kept}});
    wire nxt_cur_reg = current_regulating_in | (cur_reg_ff & ~clr_any);
    wire nxt_therm_warn = thermal_warning_in | (therm_warn_ff & ~clr_any);

    // Status bits (current regulating, thermal warning) stay out of this term
    wire fault = nxt_supply_low | nxt_logic_high | nxt_therm_sd | (|nxt_overcur)
        | sleep_ff;
    wire nxt_bridge_on = active & ~fault;

    wire meas_sgnd = (meas_current_in >= `MEAS_SHORT_GND_MIN);
    wire meas_sbat = (meas_current_in <= `MEAS_SHORT_BAT_MAX);
    wire meas_open = (meas_current_in >= `MEAS_OPEN_MIN) & (meas_current_in <= `MEAS_OPEN_MAX);

    wire [15:0] diag_word = {3'h0, short_bat_ff, overcur_ff, bridge_on_ff, therm_sd_ff,
        therm_warn_ff, cur_reg_ff, logic_high_ff, short_gnd_ff, open_load_ff,
        supply_low_ff};

    wire [`EV_WIDTH-1:0] events = {thermal_shutdown_in & ~therm_sd_ff,
        (|(overcurrent_in & ~overcur_ff)),
        (nxt_open & ~open_load_ff) | (nxt_sgnd & ~short_gnd_ff) | (nxt_sbat & ~short_bat_ff),
        lh_hit & ~logic_high_ff,
        sl_hit & ~supply_low_ff};
    // Read clears status, but an event in that cycle still sets it
    wire [`EV_WIDTH-1:0] nxt_irq_stat = events | (irq_stat_ff & ~{`EV_WIDTH{rd_stat}});
    wire [`EV_WIDTH-1:0] nxt_irq_mask = wr_mask ? avs_writedata_in[`EV_WIDTH-1:0]
        : irq_mask_ff;

    // Off-state diagnosis sequencer
    always @* begin
        nxt_diag_state = diag_state_ff;
        nxt_settle_cnt = settle_cnt_ff;
        nxt_open = open_load_ff & ~clr_any;
        nxt_sgnd = short_gnd_ff & ~clr_any;
        nxt_sbat = short_bat_ff & ~clr_any;
        case (diag_state_ff)
            ST_ON: begin
                nxt_settle_cnt = 17'h0;
                if (!bridge_on_ff) begin
                    // Skip the settle wait only for the first pass after power-up
                    nxt_diag_state = first_diag_ff ? ST_MEASURE : ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (bridge_on_ff) begin
                    nxt_diag_state = ST_ON;
                end else if (settle_cnt_ff >= IDLE_SETTLE_CYC[16:0] - 17'h1) begin
                    nxt_diag_state = ST_MEASURE;
                end else begin
                    nxt_settle_cnt = settle_cnt_ff + 17'h1;
                end
            end
            ST_MEASURE: begin
                if (bridge_on_ff) begin
                    nxt_diag_state = ST_ON;
                end else if (source_en_ff) begin
                    // Evaluate only once the source has had a cycle to act
                    nxt_open = nxt_open | meas_open;
                    nxt_sgnd = nxt_sgnd | meas_sgnd;
                    nxt_sbat = nxt_sbat | meas_sbat;
                    nxt_diag_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (bridge_on_ff) begin
                    nxt_diag_state = ST_ON;
                end
            end
            default: begin
                nxt_diag_state = ST_ON;
            end
        endcase
    end

    always @* begin
        case (avs_address_in)
            `REG_DIAG: nxt_rdata = {16'h0, diag_word};
            `REG_CTRL: nxt_rdata = {31'h0, clear_policy_ff};
            `REG_IRQ_STATUS: nxt_rdata = {{(32-`EV_WIDTH){1'b0}}, irq_stat_ff};
            `REG_IRQ_MASK: nxt_rdata = {{(32-`EV_WIDTH){1'b0}}, irq_mask_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // Supply monitors and sleep survive the soft restart
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            sl_cnt_ff <= 17'h0;
            lh_cnt_ff <= 17'h0;
            ll_cnt_ff <= 17'h0;
            supply_low_ff <= 1'b0;
            sleep_ff <= 1'b0;
            restart_ff <= 1'b0;
        end else begin
            sl_cnt_ff <= sl_nxt;
            lh_cnt_ff <= lh_nxt;
            ll_cnt_ff <= ll_nxt;
            supply_low_ff <= nxt_supply_low;
            restart_ff <= sleep_ff & logic_above_recover_in;
            if (ll_hit) begin
                sleep_ff <= 1'b1;
            end else if (logic_above_recover_in) begin
                sleep_ff <= 1'b0;
            end
        end
    end

    always @(posedge ref_clk_in) begin
        if (soft_rst) begin
            logic_high_ff <= 1'b0;
            open_load_ff <= 1'b0;
            short_gnd_ff <= 1'b0;
            short_bat_ff <= 1'b0;
            cur_reg_ff <= 1'b0;
            therm_warn_ff <= 1'b0;
            therm_sd_ff <= 1'b0;
            overcur_ff <= 4'h0;
            bridge_on_ff <= 1'b0;
            active_prev_ff <= 1'b0;
            first_diag_ff <= 1'b1;
            diag_state_ff <= ST_ON;
            settle_cnt_ff <= 17'h0;
            clear_policy_ff <= `CTRL_RESET;
            irq_stat_ff <= {`EV_WIDTH{1'b0}};
            irq_mask_ff <= {`EV_WIDTH{1'b0}};
            irq_ff <= 1'b0;
            term_a_ff <= 1'b0;
            term_b_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            source_en_ff <= 1'b0;
            fsi_ff <= 1'b0;
        end else begin
            logic_high_ff <= nxt_logic_high;
            therm_sd_ff <= nxt_therm_sd;
            overcur_ff <= nxt_overcur;
            cur_reg_ff <= nxt_cur_reg;
            therm_warn_ff <= nxt_therm_warn;
            open_load_ff <= nxt_open;
            short_gnd_ff <= nxt_sgnd;
            short_bat_ff <= nxt_sbat;
            bridge_on_ff <= nxt_bridge_on;
            active_prev_ff <= active;
            diag_state_ff <= nxt_diag_state;
            settle_cnt_ff <= nxt_settle_cnt;
            if (nxt_bridge_on) begin
                first_diag_ff <= 1'b0;
            end
            // Clear policy is configuration; a supply low leaves it alone, the logic supply restart resets it
            if (wr_ctrl) begin
                clear_policy_ff <= avs_writedata_in[`CTRL_CLEAR_POLICY];
            end
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
            term_a_ff <= nxt_bridge_on & switching_pulse_in & polarity_select_in;
            term_b_ff <= nxt_bridge_on & switching_pulse_in & ~polarity_select_in;
            oe_n_ff <= ~nxt_bridge_on;
            // Source off while the supply is low, avoids back-feeding the bridge
            source_en_ff <= ~nxt_bridge_on & ~nxt_supply_low & ~sleep_ff
                & (nxt_diag_state == ST_SETTLE || nxt_diag_state == ST_MEASURE);
            fsi_ff <= fault;
        end
    end

    // Bus answer: one wait cycle, then the access completes
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (req & wait_ff) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign avs_readdata_out = rdata_ff;
    assign avs_waitrequest_out = wait_ff;
    assign irq_out = irq_ff;
    assign bridge_terminal_a_out = term_a_ff;
    assign bridge_terminal_b_out = term_b_ff;
    assign bridge_terminal_a_oe_n_out = oe_n_ff;
    assign bridge_terminal_b_oe_n_out = oe_n_ff;
    assign meas_source_en_out = source_en_ff;
    assign sleep_out = sleep_ff;
    assign failure_summary_indicator_out = fsi_ff;

endmodule
